// ### design/t1_j1_superframe_sync.v
// Contract
// - Superframe: 12 frames, F bit plus 24x8
// - T1 searches F bits for 100011011100
// - T1 requires twelfth alignment bit zero
// - J1 ignores twelfth alignment bit value
// - Mimic select 1: two patterns, no mimic
// - Mimic select 0: two patterns suffice
// - Off-F-bit pattern sets mimic found flag; code sets it only while confirming (ST_CONF)
// - Out-of-frame zero only while synchronized
// - Multiframe start pulse at superframe bit one
// - In sync, report framing bit errors
// - Selectable out-of-frame check drops sync
// - Bypass skips search and monitoring
//
// Chosen here: the register offsets and register access over Avalon-MM.
`include "t1_j1_superframe_sync_regs.vh"

module t1_j1_superframe_sync #(
	parameter FRAMES   = 12,            // Frames per superframe
	parameter CHANNELS = 24             // Channels per frame
) (
	input  wire        clk,             // 50 MHz system clock
	input  wire        rst_b,           // Async reset, active low
	input  wire        rx_bit,          // Decoded line bit
	input  wire        rx_vld,          // Line bit strobe
	input  wire [2:0]  avs_address,     // Word address
	input  wire        avs_read,        // Read request
	input  wire        avs_write,       // Write request
	input  wire [31:0] avs_writedata,   // Write data
	output wire [31:0] avs_readdata,    // Read data
	output wire        avs_waitrequest, // Stall
	output wire        out_bit,         // Forwarded bit
	output wire        out_vld,         // Forwarded strobe
	output wire [3:0]  frame_num,       // Frame 1..12, 0 out of sync
	output wire        terminal_framing_bit,  // Bit is terminal F
	output wire        signaling_framing_bit, // Bit is signaling F
	output wire        sig_a_bit,       // Bit is signaling A
	output wire        sig_b_bit,       // Bit is signaling B
	output wire        multiframe_start_flag, // Superframe start
	output wire        out_of_frame_status,   // High when not in sync
	output wire        mimic_found_flag,      // Sticky mimic seen
	output wire        irq              // Level interrupt
);

	////////////////////////////////////////////////////////////////
	// Constants
	localparam integer BITS = 1 + 8 * CHANNELS;  // Bits per frame
	localparam integer LAST_I = BITS - 1;        // Last slot, full width
	localparam integer FR_I   = FRAMES;          // Frames, full width
	localparam [7:0] LAST_POS = LAST_I[7:0];     // Last bit slot
	localparam [3:0] FR_LAST  = FR_I[3:0];       // Frame twelve
	localparam [3:0] FR_A     = 4'h6;            // Signaling A frame
	localparam [2:0] ST_SEARCH = 3'b001;         // Hunting
	localparam [2:0] ST_CONF   = 3'b010;         // Second pattern
	localparam [2:0] ST_SYNC   = 3'b100;         // Aligned

	// Pattern match, final bit masked in J1
	function pat_match;
		input [11:0] h;
		input        j1;
		reg   [11:0] p;
		begin
			p = `SF_PATTERN;
			if (j1)
				pat_match = (h[11:1] == p[11:1]);
			else
				pat_match = (h == `SF_PATTERN);
		end
	endfunction

	// Count errors among the newest n window bits
	function [2:0] err_count;
		input [4:0] w;
		input [2:0] n;
		integer i;
		begin
			err_count = 3'h0;
			for (i = 0; i < 5; i = i + 1) begin
				if (i < n && w[i])
					err_count = err_count + 3'h1;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// State
	reg [11:0] hist_mem [0:BITS-1]; // F history per bit offset
	reg [7:0]  pos_q;      // Free-running bit slot
	reg [3:0]  warm_q;     // Frames seen since reset, holds at 12
	reg [7:0]  fpos_q;     // Slot holding the F bit
	reg [3:0]  fr_q;       // Current frame number
	reg [2:0]  cb_q;       // Bit within channel
	reg [2:0]  state_q;    // Sync state
	reg        mim_seen_q; // Mimic seen while confirming
	reg [4:0]  ewin_q;     // Recent F bit errors
	reg        oof_q;      // Out of frame
	reg [3:0]  ctrl_q;     // Control register
	reg [3:0]  st_q;       // Interrupt status
	reg [3:0]  mask_q;     // Interrupt mask
	reg [15:0] ecnt_q;     // Framing error count
	reg        irq_q;      // Interrupt output
	reg        wait_q;     // Waitrequest
	reg [31:0] rdata_q;    // Read data
	reg        obit_q;     // Forwarded bit
	reg        ovld_q;     // Forwarded strobe
	reg [3:0]  onum_q;     // Frame number out
	reg        tf_q;       // Terminal F flag
	reg        sf_q;       // Signaling F flag
	reg        sa_q;       // Signaling A flag
	reg        sb_q;       // Signaling B flag
	reg        mfs_q;      // Multiframe start

	////////////////////////////////////////////////////////////////
	// Combinational decode
	wire        bypass = ctrl_q[`CTRL_BYPASS];
	wire        j1     = ctrl_q[`CTRL_J1];
	wire [11:0] hist_rd  = hist_mem[pos_q];       // History here
	wire [11:0] hist_new = {hist_rd[10:0], rx_bit};
	wire        match  = pat_match(hist_new, j1);
	wire        warm   = (warm_q == FR_LAST);     // Histories full
	wire        is_f   = (pos_q == fpos_q);       // F bit slot
	// Frame that this F bit opens
	wire [3:0]  f_fr   = (fr_q == FR_LAST) ? 4'h1 : fr_q + 4'h1;
	wire [11:0] pat    = `SF_PATTERN;
	wire [3:0]  pidx   = FR_LAST - f_fr;          // Bit of pattern
	wire        f_last = (f_fr == FR_LAST);
	// F bit error; J1 final bit is yellow alarm, not checked
	wire        f_err  = (rx_bit != pat[pidx]) && !(j1 && f_last);
	wire        insync = (state_q == ST_SYNC);
	wire [4:0]  ewin_d = {ewin_q[3:0], f_err};
	wire [2:0]  win_n  = ctrl_q[`CTRL_OOF_SEL] ? `OOF_WIN_B
	                                           : `OOF_WIN_A;
	wire        oof_hit = err_count(ewin_d, win_n) >= `OOF_ERRS;
	wire        searching = (state_q == ST_CONF);
	// Events
	wire ev_mimic = rx_vld && !bypass && warm && searching &&
	                match && !is_f;
	wire ev_ferr  = rx_vld && !bypass && insync && is_f &&
	                f_err;
	wire ev_lost  = rx_vld && !bypass && insync && is_f && oof_hit;
	wire ev_gain  = rx_vld && !bypass && searching && is_f && !f_err &&
	                f_last && !(ctrl_q[`CTRL_MIMIC] && mim_seen_q);
	// Bus strobes
	wire        wr_en = avs_write && !wait_q;     // Write commits
	wire [3:0]  w1c   = (wr_en && avs_address == `REG_INT_STAT) ?
	                    avs_writedata[3:0] : 4'h0;
	wire [3:0]  ev    = {ev_gain, ev_lost, ev_ferr, ev_mimic};
	wire [3:0]  st_d  = (st_q & ~w1c) | ev;       // Set wins

	////////////////////////////////////////////////////////////////
	// Per-offset history store; no reset, warm_q hides garbage
	always @(posedge clk) begin
		if (rx_vld)
			hist_mem[pos_q] <= hist_new;
	end

	////////////////////////////////////////////////////////////////
	// Bit slot counter and warm-up
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_q  <= 8'h00;
			warm_q <= 4'h0;
		end else if (rx_vld) begin
			if (pos_q == LAST_POS) begin
				pos_q <= 8'h00;
				if (!warm)
					warm_q <= warm_q + 4'h1;
			end else begin
				pos_q <= pos_q + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Alignment state machine
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= ST_SEARCH;
			fpos_q     <= 8'h00;
			fr_q       <= 4'h0;
			cb_q       <= 3'h0;
			mim_seen_q <= 1'b0;
			ewin_q     <= 5'h00;
			oof_q      <= 1'b1;
		end else if (bypass) begin
			// No search or monitoring while bypassed
			state_q <= ST_SEARCH;
			oof_q   <= 1'b1;
		end else if (rx_vld) begin
			// Channel bit count restarts after each F bit
			if (is_f)
				cb_q <= 3'h0;
			else
				cb_q <= cb_q + 3'h1;
			case (state_q)
				ST_SEARCH: begin
					// First offset showing the whole pattern wins
					if (warm && match) begin
						fpos_q     <= pos_q;
						fr_q       <= FR_LAST;
						mim_seen_q <= 1'b0;
						state_q    <= ST_CONF;
					end
				end
				ST_CONF: begin
					if (ev_mimic)
						mim_seen_q <= 1'b1;
					if (is_f) begin
						fr_q <= f_fr;
						if (f_err)
							state_q <= ST_SEARCH;
						else if (f_last) begin
							// Mimic blocks sync only when selected
							if (ev_gain) begin
								state_q <= ST_SYNC;
								oof_q   <= 1'b0;
								ewin_q  <= 5'h00;
							end else begin
								state_q <= ST_SEARCH;
							end
						end
					end
				end
				ST_SYNC: begin
					if (is_f) begin
						fr_q   <= f_fr;
						ewin_q <= ewin_d;
						if (oof_hit) begin
							state_q <= ST_SEARCH;
							oof_q   <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= ST_SEARCH;
					oof_q   <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Output stream with frame markers, one cycle after input
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			obit_q <= 1'b0;
			ovld_q <= 1'b0;
			onum_q <= 4'h0;
			tf_q   <= 1'b0;
			sf_q   <= 1'b0;
			sa_q   <= 1'b0;
			sb_q   <= 1'b0;
			mfs_q  <= 1'b0;
		end else begin
			obit_q <= rx_bit;
			ovld_q <= rx_vld;
			// The F bit that drops sync carries no marker
			if (rx_vld && insync && !bypass && !ev_lost) begin
				onum_q <= is_f ? f_fr : fr_q;
				tf_q   <= is_f && f_fr[0];
				sf_q   <= is_f && !f_fr[0];
				sa_q   <= !is_f && cb_q == 3'h7 &&
				          fr_q == FR_A;
				sb_q   <= !is_f && cb_q == 3'h7 &&
				          fr_q == FR_LAST;
				mfs_q  <= is_f && f_fr == 4'h1;
			end else begin
				onum_q <= 4'h0;
				tf_q   <= 1'b0;
				sf_q   <= 1'b0;
				sa_q   <= 1'b0;
				sb_q   <= 1'b0;
				mfs_q  <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Registers, interrupts and error counter
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= `CTRL_RESET;
			mask_q <= `INT_RESET;
			st_q   <= `INT_RESET;
			irq_q  <= 1'b0;
			ecnt_q <= 16'h0000;
		end else begin
			st_q  <= st_d;
			irq_q <= |(st_d & mask_q);
			if (wr_en && avs_address == `REG_CTRL)
				ctrl_q <= avs_writedata[3:0];
			if (wr_en && avs_address == `REG_INT_MASK)
				mask_q <= avs_writedata[3:0];
			// Count saturates; an error beats a clearing write
			if (ev_ferr) begin
				if (ecnt_q != 16'hFFFF)
					ecnt_q <= ecnt_q + 16'h0001;
			end else if (wr_en && avs_address == `REG_ERR_CNT) begin
				ecnt_q <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Avalon slave: every access answers after one wait cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end else if (!wait_q) begin
			wait_q <= 1'b1;
		end else if (avs_read || avs_write) begin
			wait_q  <= 1'b0;
			rdata_q <= 32'h00000000;
			if (avs_read) begin
				case (avs_address)
					`REG_CTRL:     rdata_q[3:0] <= ctrl_q;
					`REG_STATUS:   rdata_q[7:0] <= {onum_q,
					               state_q == ST_CONF, insync,
					               state_q == ST_SEARCH, oof_q};
					`REG_INT_STAT: rdata_q[3:0] <= st_q;
					`REG_INT_MASK: rdata_q[3:0] <= mask_q;
					`REG_ERR_CNT:  rdata_q[15:0] <= ecnt_q;
					default:       rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Port drive, all from flip-flops
	assign avs_readdata          = rdata_q;
	assign avs_waitrequest       = wait_q;
	assign out_bit               = obit_q;
	assign out_vld               = ovld_q;
	assign frame_num             = onum_q;
	assign terminal_framing_bit  = tf_q;
	assign signaling_framing_bit = sf_q;
	assign sig_a_bit             = sa_q;
	assign sig_b_bit             = sb_q;
	assign multiframe_start_flag = mfs_q;
	assign out_of_frame_status   = oof_q;
	assign mimic_found_flag      = st_q[`INT_MIMIC];
	assign irq                   = irq_q;

endmodule // t1_j1_superframe_sync

// ### pkg/t1_j1_superframe_sync_regs.vh
`ifndef T1_J1_SUPERFRAME_SYNC_REGS_VH
`define T1_J1_SUPERFRAME_SYNC_REGS_VH
// Register word offsets (Avalon word address)
`define REG_CTRL      3'h0
`define REG_STATUS    3'h1
`define REG_INT_STAT  3'h2
`define REG_INT_MASK  3'h3
`define REG_ERR_CNT   3'h4
// Control field positions
`define CTRL_BYPASS   0
`define CTRL_MIMIC    1
`define CTRL_J1       2
`define CTRL_OOF_SEL  3
`define CTRL_RESET    4'h0
// Interrupt status field positions
`define INT_MIMIC     0
`define INT_FERR      1
`define INT_LOST      2
`define INT_GAIN      3
`define INT_RESET     4'h0
// Alignment sequence, frame 1 in the top bit
`define SF_PATTERN    12'h8DC
// Framing error window sizes and threshold
`define OOF_WIN_A     3'h4
`define OOF_WIN_B     3'h5
`define OOF_ERRS      3'h2
`endif

// ### verif/sf_monitor.sv
module sf_monitor #(
	parameter FRAMES   = 12,           // Frames per superframe
	parameter CHANNELS = 24            // Channels per frame
) (
	input wire        clk, rst_b, rx_bit, rx_vld, // Clock, reset, line
	input wire [2:0]  avs_address,     // Word address
	input wire        avs_read, avs_write,        // Bus requests
	input wire [31:0] avs_writedata, avs_readdata, // Bus data
	input wire        avs_waitrequest, out_bit, out_vld, // Stall, output
	input wire [3:0]  frame_num,       // Frame of output bit
	input wire        terminal_framing_bit, signaling_framing_bit,
	input wire        sig_a_bit, sig_b_bit, multiframe_start_flag,
	input wire        out_of_frame_status, mimic_found_flag, irq
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Line bits always pass, also in bypass
	vld_pass_a: assert property (out_vld == $past(rx_vld))
		else $error("strobe not forwarded");
	bit_pass_a: assert property ($past(rx_vld) |-> out_bit == $past(rx_bit))
		else $error("bit not forwarded");
	mf_start_a: assert property (multiframe_start_flag |-> frame_num == 4'h1
		&& terminal_framing_bit && out_vld) else $error("bad superframe start");
	term_odd_a: assert property (terminal_framing_bit |-> frame_num[0]
		&& !out_of_frame_status) else $error("terminal bit misplaced");
	sig_even_a: assert property (signaling_framing_bit |-> !frame_num[0]
		&& frame_num != 4'h0) else $error("signaling bit misplaced");
	sig_a_pos_a: assert property (sig_a_bit |-> frame_num == 4'h6)
		else $error("A bit outside frame 6");
	sig_b_pos_a: assert property (sig_b_bit |-> frame_num == 4'hC)
		else $error("B bit outside frame 12");
	// No alignment flags while out of frame
	oof_quiet_a: assert property (out_of_frame_status |-> !(sig_a_bit ||
		sig_b_bit || terminal_framing_bit || signaling_framing_bit ||
		multiframe_start_flag)) else $error("flag while out of frame");
	// Frames count up and wrap after the last one
	frame_step_a: assert property (frame_num != 4'h0 && $past(frame_num) !=
		4'h0 && frame_num != $past(frame_num) |-> frame_num ==
		(($past(frame_num) == FRAMES) ? 4'h1 : $past(frame_num) + 4'h1))
		else $error("frame number skipped");
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("answer late");
	wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held too long");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
		avs_address > 3'h4 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	// Sticky until a one is written to its status bit
	mimic_hold_a: assert property (mimic_found_flag && !(avs_write &&
		!avs_waitrequest && avs_address == 3'h2 && avs_writedata[0])
		|=> mimic_found_flag) else $error("mimic flag dropped");
endmodule // sf_monitor
bind t1_j1_superframe_sync sf_monitor #(.FRAMES(FRAMES),
	.CHANNELS(CHANNELS)) u_mon (.*);

// ### verif/line_source.sv
module line_source (
	input  wire  clk, rst_b, en,   // Clock, reset, stream on
	input  wire  j1_last, f_err,   // Frame 12 F value, invert F bits
	input  wire  mimic,            // Copy F pattern into data bit 1
	output logic rx_bit, rx_vld    // Line bit and strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  pos_q;            // Bit in frame, 0 is the F bit
	logic [3:0]  frm_q;            // Frame 0..11
	logic [11:0] pat;              // Alignment sequence, frame 1 on top
	logic        f_val;            // Clean F bit of this frame
	assign pat = 12'h8DC;
	assign f_val = (frm_q == 4'hB) ? j1_last : pat[4'hB - frm_q];
	////////////////////////////////////////////////////////////////////
	// Data bits are zero so only the F offset matches, unless mimic
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_q <= 8'h00;
			frm_q <= 4'h0;
			rx_vld <= 1'b0;
			rx_bit <= 1'b0;
		end else begin
			rx_vld <= en;
			if (en) begin
				rx_bit <= (pos_q == 8'h00) ? f_val ^ f_err :
					(pos_q == 8'h01) & mimic & f_val;
				pos_q <= (pos_q == 8'hC0) ? 8'h00 : pos_q + 8'h01;
				if (pos_q == 8'hC0)
					frm_q <= (frm_q == 4'hB) ? 4'h0 : frm_q + 4'h1;
			end else
				rx_bit <= ~rx_bit; // No stale bit between bursts
		end
	end
endmodule // line_source

// ### verif/t1_j1_superframe_sync_test.sv
`include "t1_j1_superframe_sync_regs.vh"
module t1_j1_superframe_sync_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_b, en, j1_last, f_err, mimic, avs_read, avs_write;
	logic [2:0]  avs_address;      // Bus address
	logic [31:0] avs_writedata, rdata; // Write data, last read
	wire         rx_bit, rx_vld, avs_waitrequest, oof, mf, irq;
	wire         mim;              // Sticky mimic flag
	wire  [31:0] avs_readdata;     // Read data
	wire  [3:0]  frame_num;        // Frame of output bit
	integer      fails, compares, mfs; // Mismatches, checks, start pulses
	integer      cycles = 0;       // Clock cycles run
	line_source u_src (.clk(clk), .rst_b(rst_b), .en(en), .j1_last(j1_last),
		.f_err(f_err), .mimic(mimic), .rx_bit(rx_bit), .rx_vld(rx_vld));
	t1_j1_superframe_sync u_dut (.clk(clk), .rst_b(rst_b), .rx_bit(rx_bit),
		.rx_vld(rx_vld), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.out_bit(), .out_vld(), .frame_num(frame_num),
		.terminal_framing_bit(), .signaling_framing_bit(), .sig_a_bit(),
		.sig_b_bit(), .multiframe_start_flag(mf), .out_of_frame_status(oof),
		.mimic_found_flag(mim), .irq(irq));
	////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, s);
		compares = compares + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	// One Avalon cycle; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [2:0] a, input [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input [31:0] e, m);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %0d", a), e, rdata & m);
	endtask
	// Run up to n cycles, stopping early on lock if asked
	task automatic run(input integer n, input logic stop);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			if (mf === 1'b1) mfs = mfs + 1;
			if (stop && oof === 1'b0) break;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard: the whole sequence needs about 40000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fails = fails + 1;
			end_sim;
		end
	end
	initial begin
		{rst_b, en, j1_last, f_err, mimic, avs_read, avs_write} = 7'h00;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		{fails, compares, mfs} = 96'h0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd(`REG_CTRL, 32'h0, 32'hFFFFFFFF);
		rd(`REG_INT_MASK, 32'h0, 32'hFFFFFFFF);
		rd(`REG_STATUS, 32'h1, 32'h1);
		rd(3'h7, 32'h0, 32'hFFFFFFFF);
		bus(1'b1, `REG_INT_MASK, 32'hF);
		// Mimic present but select 0: lock anyway, flag mimic
		en <= 1'b1;
		mimic <= 1'b1;
		run(9000, 1'b1);
		chk("oof", 32'h0, oof);
		chk("mimic", 32'h1, mim);
		chk("irq", 32'h1, irq);
		rd(`REG_INT_STAT, 32'h9, 32'h9);
		bus(1'b1, `REG_INT_STAT, 32'hF);
		mimic <= 1'b0;
		run(2, 1'b0);
		chk("irq", 32'h0, irq);
		// Two F errors in a row drop sync, counted while locked
		f_err <= 1'b1;
		run(400, 1'b0);
		f_err <= 1'b0;
		run(5, 1'b0);
		chk("oof", 32'h1, oof);
		rd(`REG_ERR_CNT, 32'h2, 32'hFFFF);
		rd(`REG_INT_STAT, 32'h6, 32'h6);
		bus(1'b1, `REG_INT_MASK, 32'h0);
		run(2, 1'b0);
		chk("irq masked", 32'h0, irq);
		bus(1'b1, `REG_INT_STAT, 32'hF);
		// Select 1: a mimic blocks lock, its absence allows it;
		// bypass first so the mimic history is full before search
		bus(1'b1, `REG_CTRL, 32'h3);
		mimic <= 1'b1;
		run(2400, 1'b0);
		bus(1'b1, `REG_CTRL, 32'h2);
		run(9000, 1'b1);
		chk("oof", 32'h1, oof);
		mimic <= 1'b0;
		run(9000, 1'b1);
		chk("oof", 32'h0, oof);
		// Bypass forces search; bits still flow
		bus(1'b1, `REG_CTRL, 32'h1);
		run(3, 1'b0);
		chk("oof", 32'h1, oof);
		chk("frame", 32'h0, frame_num);
		// Final F bit one: refused in T1, accepted in J1
		j1_last <= 1'b1;
		bus(1'b1, `REG_CTRL, 32'h0);
		run(9000, 1'b1);
		chk("oof", 32'h1, oof);
		// J1 with the five-bit loss window
		bus(1'b1, `REG_CTRL, 32'hC);
		run(9000, 1'b1);
		chk("oof", 32'h0, oof);
		// One superframe of bits holds exactly one start pulse
		mfs = 0;
		run(2316, 1'b0);
		chk("mf count", 32'h1, mfs);
		// Frame 12 F is never an error in J1, so span three F bits
		f_err <= 1'b1;
		run(600, 1'b0);
		f_err <= 1'b0;
		run(5, 1'b0);
		chk("oof", 32'h1, oof);
		end_sim;
	end
endmodule // t1_j1_superframe_sync_test
